// File: src/bus_seq_consts.vh
// shared constants of the bus cycle sequencer: offsets, fields, resets, codes
`ifndef BUS_SEQ_CONSTS_VH
`define BUS_SEQ_CONSTS_VH

// ****************************************************************
// register byte offsets on the bus
// ****************************************************************
`define OFS_MODE 4'h0
`define OFS_WAIT 4'h4
`define OFS_STAT 4'h8

// ****************************************************************
// operation mode control fields and reset values
// ****************************************************************
`define MODE_FSE_BIT 7
`define MODE_ARM_BIT 6
`define MODE_IOC_BIT 5
`define MODE_FSE_RST 1'b1
`define MODE_IOC_RST 1'b1

// ****************************************************************
// wait control fields and reset values
// ****************************************************************
`define WAIT_MEM_HI 7
`define WAIT_MEM_LO 6
`define WAIT_IO_HI 5
`define WAIT_IO_LO 4
`define WAIT_MEM_RST 2'h3
`define WAIT_IO_RST 2'h3

// ****************************************************************
// cycle kinds on the request port
// ****************************************************************
`define K_INTERNAL 4'h0
`define K_FETCH 4'h1
`define K_MEM_RD 4'h2
`define K_MEM_WR 4'h3
`define K_IO_RD 4'h4
`define K_IO_WR 4'h5
`define K_EXTERNAL_INTERRUPT_LEVEL0_ACK 4'h6
`define K_NMI_ACK 4'h7
`define K_RETURN_FROM_INTERRUPT_1 4'h8
`define K_RETURN_FROM_INTERRUPT_2 4'h9

// ****************************************************************
// timing count and restart address
// ****************************************************************
`define RST_MIN_CLOCKS 3'h6
`define RESTART_ADDR 20'h00000

`endif

// File: src/bus_cycle_sequencer.v
// external bus cycle sequencer with its operation mode register on ahb-lite
// Behaviour
// - reset sets fetch strobe enable bit 7
// - enable one: strobe on fetches, acks, return_from_interrupt
// - enable zero: strobe only return_from_interrupt refetch, external_interrupt_level0
// - temporary arm bit six reads one
// - writing zero arms strobe for next fetch
// - io timing bit five resets one, legacy
// - io timing zero: strobes at t2 rise
// - bus cycles t1 t2 t3, internal one
// - system clock is input clock halved
// - fetch: address t1, strobes second half
// - fetch data latched t3 rise, ends t3
// - wait sampled t2 fall, holds, proceeds
// - wait combines pin and generator
// - reads latch at t3 fall, no strobe
// - writes: request first, then data and write strobe together at t2 rise
// - io: io request, 16-bit address, top low
// - external io gets at least one wait
// - reset pin six clocks restarts at zero
// - wait count is max of both sources
// - generator resets to three and four waits
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "bus_seq_consts.vh"

module bus_cycle_sequencer (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire cyc_valid,
  input wire [3:0] cyc_kind,
  input wire [19:0] cyc_addr,
  input wire [7:0] cyc_wdata,
  input wire cyc_io_internal,
  output reg cyc_ready,
  output reg cyc_done,
  output reg [7:0] cyc_rdata,
  output reg restart,
  input wire reset_pin_n,
  input wire wait_n,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  output reg [19:0] addr_out,
  output reg sys_clk,
  output reg mem_req_n,
  output reg io_req_n,
  output reg rd_n,
  output reg wr_n,
  output reg fetch_cycle_strobe_n
);

  // ****************************************************************
  // states, one-hot
  // ****************************************************************
  reg [5:0] state_q;
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_TI = 6'h02;
  localparam [5:0] ST_T1 = 6'h04;
  localparam [5:0] ST_T2 = 6'h08;
  localparam [5:0] ST_TW = 6'h10;
  localparam [5:0] ST_T3 = 6'h20;

  // ****************************************************************
  // functions
  // ****************************************************************
  // programmed wait count for one cycle kind
  function [2:0] wait_need;
    input [3:0] kind;
    input internal;
    input [1:0] mwi;
    input [1:0] iwi;
    begin
      case (kind)
        // external io waits one at least
        `K_IO_RD, `K_IO_WR: wait_need = internal ? 3'h0 : ({1'b0, iwi} + 3'h1);
        `K_EXTERNAL_INTERRUPT_LEVEL0_ACK: wait_need = (iwi == 2'h0) ? 3'h2 : ({1'b0, iwi} + 3'h3);
        `K_NMI_ACK: wait_need = 3'h0;
        default: wait_need = {1'b0, mwi};
      endcase
    end
  endfunction

  // kinds that latch at the rising edge of t3
  function is_fetchlike;
    input [3:0] kind;
    begin
      is_fetchlike = (kind == `K_FETCH) || (kind == `K_EXTERNAL_INTERRUPT_LEVEL0_ACK) ||
                     (kind == `K_NMI_ACK) || (kind == `K_RETURN_FROM_INTERRUPT_1) || (kind == `K_RETURN_FROM_INTERRUPT_2);
    end
  endfunction

  // ****************************************************************
  // register state
  // ****************************************************************
  reg fse_q;
  reg ioc_q;
  reg arm_q;
  reg [1:0] mwi_q;
  reg [1:0] iwi_q;
  reg wr_pend_q;
  reg [3:0] waddr_q;
  reg ph_q;
  reg [2:0] rcnt_q;
  reg [3:0] kind_q;
  reg internal_q;
  reg [7:0] wdata_q;
  reg [2:0] wcnt_q;
  reg go_tw_q;

  wire rst_hold = (rcnt_q >= `RST_MIN_CLOCKS);
  wire addr_ok = hsel && hready && htrans[1];
  wire mode_wr = wr_pend_q && (waddr_q == `OFS_MODE);
  wire take = (state_q == ST_IDLE) && ph_q && cyc_ready && cyc_valid && !rst_hold;
  wire is_io = (cyc_kind == `K_IO_RD) || (cyc_kind == `K_IO_WR);
  wire k_io = (kind_q == `K_IO_RD) || (kind_q == `K_IO_WR);
  wire k_rd = (kind_q == `K_MEM_RD) || (kind_q == `K_IO_RD) || is_fetchlike(kind_q);
  wire k_wr = (kind_q == `K_MEM_WR) || (kind_q == `K_IO_WR);
  wire arms_fetch = (cyc_kind == `K_FETCH) || (cyc_kind == `K_RETURN_FROM_INTERRUPT_1) ||
                    (cyc_kind == `K_RETURN_FROM_INTERRUPT_2);
  reg strobe_pick;

  // fetch strobe choice for the incoming cycle
  always @* begin
    case (cyc_kind)
      `K_FETCH: strobe_pick = fse_q || arm_q;
      `K_NMI_ACK: strobe_pick = fse_q;
      `K_RETURN_FROM_INTERRUPT_1: strobe_pick = fse_q || arm_q;
      `K_EXTERNAL_INTERRUPT_LEVEL0_ACK: strobe_pick = 1'b1;
      `K_RETURN_FROM_INTERRUPT_2: strobe_pick = 1'b1;
      default: strobe_pick = 1'b0;
    endcase
  end

  // ****************************************************************
  // ahb-lite slave, zero wait, always okay
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 4'h0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        waddr_q <= haddr[3:0];
      end
      // read data is set up during the address phase so it leaves a flop
      if (addr_ok && !hwrite && (haddr[31:4] == 28'h0000000)) begin
        case (haddr[3:0])
          `OFS_MODE: hrdata <= {24'h000000, fse_q, 1'b1, ioc_q, 5'h00};
          `OFS_WAIT: hrdata <= {24'h000000, mwi_q, iwi_q, 4'h0};
          `OFS_STAT: hrdata <= {16'h0000, cyc_rdata, 2'h0, state_q};
          default: hrdata <= 32'h00000000;
        endcase
      end else if (addr_ok) begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // mode and wait generator registers
  // ****************************************************************
  // hardware reset through the pin reloads them as well as hresetn
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fse_q <= `MODE_FSE_RST;
      ioc_q <= `MODE_IOC_RST;
      arm_q <= 1'b0;
      mwi_q <= `WAIT_MEM_RST;
      iwi_q <= `WAIT_IO_RST;
    end else if (rst_hold) begin
      fse_q <= `MODE_FSE_RST;
      ioc_q <= `MODE_IOC_RST;
      arm_q <= 1'b0;
      mwi_q <= `WAIT_MEM_RST;
      iwi_q <= `WAIT_IO_RST;
    end else begin
      if (mode_wr) begin
        fse_q <= hwdata[`MODE_FSE_BIT];
        ioc_q <= hwdata[`MODE_IOC_BIT];
      end
      // one-shot arm; a new arm wins over consumption
      if (mode_wr && !hwdata[`MODE_ARM_BIT]) begin
        arm_q <= 1'b1;
      end else if (take && arms_fetch) begin
        arm_q <= 1'b0;
      end
      if (wr_pend_q && (waddr_q == `OFS_WAIT)) begin
        mwi_q <= hwdata[`WAIT_MEM_HI:`WAIT_MEM_LO];
        iwi_q <= hwdata[`WAIT_IO_HI:`WAIT_IO_LO];
      end
    end
  end

  // ****************************************************************
  // clock halving and reset pin watch
  // ****************************************************************
  // system clock toggles every input clock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      sys_clk <= 1'b1;
      rcnt_q <= 3'h0;
      restart <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      sys_clk <= ph_q;
      restart <= 1'b0;
      // count system clocks with the pin low
      if (!reset_pin_n) begin
        if (ph_q && !rst_hold) begin
          rcnt_q <= rcnt_q + 3'h1;
        end
      end else begin
        rcnt_q <= 3'h0;
        restart <= rst_hold;
      end
    end
  end

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************
  // ph_q low: this edge is the falling edge; high: next system clock starts
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      kind_q <= `K_INTERNAL;
      internal_q <= 1'b0;
      wdata_q <= 8'h00;
      wcnt_q <= 3'h0;
      go_tw_q <= 1'b0;
      cyc_ready <= 1'b1;
      cyc_done <= 1'b0;
      cyc_rdata <= 8'h00;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      addr_out <= `RESTART_ADDR;
      mem_req_n <= 1'b1;
      io_req_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      fetch_cycle_strobe_n <= 1'b1;
    end else if (rst_hold) begin
      // processing stops, restart address on the bus
      state_q <= ST_IDLE;
      go_tw_q <= 1'b0;
      cyc_ready <= 1'b0;
      cyc_done <= 1'b0;
      data_oe <= 1'b0;
      addr_out <= `RESTART_ADDR;
      mem_req_n <= 1'b1;
      io_req_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      fetch_cycle_strobe_n <= 1'b1;
    end else if (!ph_q) begin
      cyc_done <= 1'b0;
      case (state_q)
        ST_T1: begin
          // strobes in second half of t1
          if (!k_io) begin
            mem_req_n <= 1'b0;
            rd_n <= !k_rd;
          end else if (ioc_q) begin
            // legacy io strobes at t1 fall
            io_req_n <= 1'b0;
            rd_n <= !k_rd;
          end
        end
        ST_T2, ST_TW: begin
          // sample at fall; pin or generator
          go_tw_q <= !wait_n ||
                     (wcnt_q < wait_need(kind_q, internal_q, mwi_q, iwi_q));
        end
        ST_T3: begin
          if (k_rd && !is_fetchlike(kind_q)) begin
            cyc_rdata <= data_in;
          end
          // strobes released in second half of t3
          mem_req_n <= 1'b1;
          io_req_n <= 1'b1;
          rd_n <= 1'b1;
          wr_n <= 1'b1;
        end
        default: begin
          go_tw_q <= go_tw_q;
        end
      endcase
    end else begin
      cyc_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cyc_ready <= 1'b1;
          if (take) begin
            kind_q <= cyc_kind;
            internal_q <= cyc_io_internal;
            wdata_q <= cyc_wdata;
            wcnt_q <= 3'h0;
            cyc_ready <= 1'b0;
            if (cyc_kind == `K_INTERNAL) begin
              state_q <= ST_TI;
            end else begin
              state_q <= ST_T1;
              // io address untranslated, top lines low
              addr_out <= is_io ? {4'h0, cyc_addr[15:0]} : cyc_addr;
              // fetch strobe for the whole cycle
              fetch_cycle_strobe_n <= !strobe_pick;
            end
          end
        end
        ST_TI: begin
          state_q <= ST_IDLE;
          cyc_done <= 1'b1;
          cyc_ready <= 1'b1;
        end
        ST_T1: begin
          state_q <= ST_T2;
          // data from end of t1, write strobe at t2
          if (k_wr) begin
            data_out <= wdata_q;
            data_oe <= 1'b1;
            wr_n <= 1'b0;
          end
          if (k_io && !ioc_q) begin
            io_req_n <= 1'b0;
            rd_n <= !k_rd;
          end
        end
        ST_T2, ST_TW: begin
          // address and strobes held during tw
          if (go_tw_q) begin
            state_q <= ST_TW;
            wcnt_q <= wcnt_q + 3'h1;
          end else begin
            state_q <= ST_T3;
            if (is_fetchlike(kind_q)) begin
              cyc_rdata <= data_in;
            end
          end
        end
        ST_T3: begin
          // cycle ends at end of t3
          state_q <= ST_IDLE;
          data_oe <= 1'b0;
          fetch_cycle_strobe_n <= 1'b1;
          cyc_done <= 1'b1;
          cyc_ready <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: test/seq_props_properties.sv
// assertions on the port timing of the bus cycle sequencer
`timescale 1ns/1ps
module seq_props (
  input wire hclk,
  input wire hresetn,
  input wire reset_pin_n,
  input wire cyc_io_internal,
  input wire cyc_ready,
  input wire cyc_done,
  input wire restart,
  input wire sys_clk,
  input wire data_oe,
  input wire [19:0] addr_out,
  input wire mem_req_n,
  input wire io_req_n,
  input wire wr_n
);
  reg [4:0] low_q;
  reg high_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // length of the latest low stretch of the pin, held after release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= 5'h00;
      high_q <= 1'b1;
    end else if (reset_pin_n) begin
      high_q <= 1'b1;
    end else if (high_q) begin
      low_q <= 5'h01;
      high_q <= 1'b0;
    end else if (low_q != 5'h1f) begin
      low_q <= low_q + 5'h01;
    end
  end
  // ********
  // steps of the bus cycles
  // ********
  sequence wr_go;
    $fell(wr_n) && io_req_n;
  endsequence
  sequence oe_drop;
    mem_req_n && data_oe ##1 !data_oe;
  endsequence
  sequence io_hold;
    !io_req_n [*5];
  endsequence
  a_clock_halved: assert property ($past(hresetn) |-> sys_clk != $past(sys_clk))
    else $error("system clock stalled");
  a_io_min_wait: assert property ($fell(io_req_n) && !cyc_io_internal |-> io_hold)
    else $error("io cycle without wait");
  a_io_top_low: assert property (!io_req_n |-> addr_out[19:16] == 4'h0)
    else $error("io address top not low");
  a_addr_hold: assert property (!mem_req_n && !$past(mem_req_n) |-> $stable(addr_out))
    else $error("address moved in cycle");
  a_write_order: assert property (wr_go |-> !$past(mem_req_n) && data_oe)
    else $error("write strobe out of order");
  a_write_release: assert property ($rose(wr_n) && io_req_n |-> oe_drop)
    else $error("write data release wrong");
  a_pin_restart: assert property (restart |-> low_q >= 5'h0b)
    else $error("restart after short reset");
  a_pin_idle: assert property (!high_q && low_q >= 5'h0e && !reset_pin_n |->
    addr_out == 20'h00000 && mem_req_n && io_req_n && !cyc_ready)
    else $error("pin reset not idle");
  a_done_pulse: assert property (cyc_done |-> cyc_ready ##1 !cyc_done)
    else $error("done not one pulse");
endmodule
bind bus_cycle_sequencer seq_props props_i (.hclk, .hresetn, .reset_pin_n, .cyc_io_internal,
  .cyc_ready, .cyc_done, .restart, .sys_clk, .data_oe, .addr_out, .mem_req_n, .io_req_n, .wr_n);

// File: test/bus_memory.sv
// far side memory and peripheral model with a wait stretcher
`timescale 1ns/1ps
module bus_memory (
  input wire hclk,
  input wire [19:0] addr_out,
  input wire [7:0] data_out,
  input wire mem_req_n,
  input wire io_req_n,
  input wire rd_n,
  input wire wr_n,
  input wire [3:0] stall,
  output logic [7:0] data_in,
  output logic wait_n
);
  logic [7:0] mem [0:15];
  logic [7:0] last_q = 8'h00;
  logic [3:0] busy_q = 4'h0;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'ha0 + 8'(i);
  end
  // a released bus shows the inverse of the last byte, never a stale copy
  always_comb data_in = rd_n ? ~last_q : mem[addr_out[3:0]];
  // slow device holds wait low for its first stall clocks
  always_comb wait_n = busy_q >= stall;
  // store writes, remember reads, time each strobe
  always @(posedge hclk) begin
    if (!wr_n) mem[addr_out[3:0]] <= data_out;
    if (!rd_n) last_q <= data_in;
    busy_q <= (mem_req_n && io_req_n) ? 4'h0 : busy_q + 4'h1;
  end
endmodule

// File: test/testbench.sv
// self-checking bench of the bus cycle sequencer
`timescale 1ns/1ps
`include "bus_seq_consts.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic cyc_valid = 1'b0;
  logic [3:0] cyc_kind = 4'h0;
  logic [19:0] cyc_addr = 20'h0;
  logic [7:0] cyc_wdata = 8'h0;
  logic cyc_io_internal = 1'b0;
  logic reset_pin_n = 1'b1;
  logic [3:0] stall = 4'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, cyc_ready, cyc_done, restart, wait_n, data_oe, sys_clk;
  wire mem_req_n, io_req_n, rd_n, wr_n, fetch_cycle_strobe_n;
  wire [7:0] cyc_rdata, data_in, data_out;
  wire [19:0] addr_out;
  int bad_count = 0;
  int n_tests = 0;
  int lat, nio;
  logic fs, rs;
  logic [31:0] r;
  // free running clock
  always #5 hclk = ~hclk;
  bus_cycle_sequencer dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cyc_valid,
    .cyc_kind, .cyc_addr, .cyc_wdata, .cyc_io_internal, .cyc_ready, .cyc_done, .cyc_rdata,
    .restart, .reset_pin_n, .wait_n, .data_in, .data_out, .data_oe, .addr_out, .sys_clk,
    .mem_req_n, .io_req_n, .rd_n, .wr_n, .fetch_cycle_strobe_n);
  bus_memory far (.hclk, .addr_out, .data_out, .mem_req_n, .io_req_n, .rd_n, .wr_n,
    .stall, .data_in, .wait_n);
  // ********
  // shared tasks
  // ********
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task hang;
    bad_count++;
    results();
  endtask
  // wait for hready at a rising edge, bounded
  task hr;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) hang();
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hr();
    htrans <= 2'h0;
    hwdata <= d;
    hr();
    r = hrdata;
    chk("okay", hresp, 1'b0);
  endtask
  // one machine cycle: hold the request until taken, then time it
  task cyc(input logic [3:0] k, input logic [19:0] a, input logic [7:0] d, input logic io);
    int i;
    @(posedge hclk);
    cyc_valid <= 1'b1;
    cyc_kind <= k;
    cyc_addr <= a;
    cyc_wdata <= d;
    cyc_io_internal <= io;
    i = 0;
    do begin
      @(posedge hclk);
      #1;
      i++;
    end while (cyc_ready === 1'b1 && i < 99);
    if (cyc_ready === 1'b1) hang();
    fs = !fetch_cycle_strobe_n;
    nio = 0;
    lat = 0;
    do begin
      @(posedge hclk);
      cyc_valid <= 1'b0;
      #1;
      lat++;
      fs |= !fetch_cycle_strobe_n;
      nio += !io_req_n;
    end while (cyc_done !== 1'b1 && lat < 99);
    if (lat >= 99) hang();
  endtask
  task pin(input int n);
    @(posedge hclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge hclk);
    reset_pin_n <= 1'b1;
    rs = 0;
    repeat (4) begin
      @(posedge hclk);
      #1;
      rs |= restart;
    end
  endtask
  // ********
  // scenarios
  // ********
  task regs_reset;
    ahb(0, `OFS_MODE, 0);
    chk("mode", r[7:0], 8'he0);
    ahb(0, `OFS_WAIT, 0);
    chk("wait", r[7:0], 8'hf0);
    ahb(0, 32'hc, 0);
    chk("unmapped", r, 32'h0);
    // software clears the enable and sets the mode before any io cycle
    ahb(1, `OFS_MODE, 32'h60);
    cyc(`K_MEM_RD, 20'h5, 0, 0);
    chk("mem lat", lat, 12);
    cyc(`K_IO_RD, 20'h5, 0, 0);
    chk("io lat", lat, 14);
  endtask
  task lengths;
    ahb(1, `OFS_WAIT, 0);
    cyc(`K_MEM_WR, 20'h5, 8'h3c, 0);
    chk("wr lat", lat, 6);
    cyc(`K_MEM_RD, 20'h5, 0, 0);
    chk("rd data", cyc_rdata, 8'h3c);
    chk("rd strobe", fs, 0);
    cyc(`K_FETCH, 20'h5, 0, 0);
    chk("fetch data", cyc_rdata, 8'h3c);
    cyc(`K_INTERNAL, 0, 0, 0);
    chk("int lat", lat, 2);
    cyc(`K_IO_WR, 20'hfffff, 8'h11, 0);
    chk("io wait", lat, 8);
    cyc(`K_IO_WR, 20'h12, 8'h11, 1);
    chk("io int", lat, 6);
  endtask
  // every cycle kind except internal with the enable bit off, then on
  task strobes;
    logic e;
    for (int f = 0; f < 2; f++) begin
      ahb(1, `OFS_MODE, f ? 32'hc0 : 32'h40);
      for (int k = 1; k < 10; k++) begin
        e = k == 6 || k == 9 || (f == 1 && (k == 1 || k == 7 || k == 8));
        cyc(k[3:0], 20'h5, 8'h3c, 0);
        chk("fetch strobe", fs, e);
      end
    end
  endtask
  task arm_once;
    ahb(1, `OFS_MODE, 32'h0);
    ahb(0, `OFS_MODE, 0);
    chk("arm reads", r[7:0], 8'h40);
    cyc(`K_FETCH, 20'h5, 0, 0);
    chk("armed", fs, 1);
    cyc(`K_FETCH, 20'h5, 0, 0);
    chk("one shot", fs, 0);
    cyc(`K_IO_RD, 20'hfffff, 0, 0);
    chk("io late", nio, 5);
    ahb(1, `OFS_MODE, 32'h20);
    cyc(`K_IO_RD, 20'hfffff, 0, 0);
    chk("io legacy", nio, 6);
  endtask
  task stalls;
    stall <= 4'h6;
    cyc(`K_MEM_RD, 20'h5, 0, 0);
    chk("pin wait", lat, 12);
    ahb(1, `OFS_WAIT, 32'hc0);
    stall <= 4'h2;
    cyc(`K_MEM_RD, 20'h5, 0, 0);
    chk("max wait", lat, 12);
    stall <= 4'h0;
  endtask
  task pin_reset;
    ahb(1, `OFS_MODE, 32'h40);
    pin(4);
    chk("short pin", rs, 0);
    pin(16);
    chk("restart", rs, 1);
    ahb(0, `OFS_MODE, 0);
    chk("mode reload", r[7:0], 8'he0);
    cyc(`K_FETCH, 20'h5, 0, 0);
    chk("reload fetch", fs, 1);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    regs_reset();
    lengths();
    strobes();
    arm_once();
    stalls();
    pin_reset();
    results();
  end
endmodule
